// >>> rtl/pin_mux_pkg.sv
// package: offsets, reset values, field positions and codes for the pin mux and fiber control
package pin_mux_pkg;
  localparam logic [11:0] pin_function_select_off = 12'h01e0;
  localparam logic [11:0] fiber_sgmii_control_off = 12'h0c00;
  localparam logic [15:0] pin_function_select_rst = 16'h417a;
  localparam logic [15:0] fiber_sgmii_control_rst = 16'h1140;
  localparam int pin0_sel_lsb        = 0;
  localparam int pin1_sel_lsb        = 4;
  localparam int fiber_soft_reset    = 15;
  localparam int mac_side_loopback   = 14;
  localparam int speed_code_low      = 13;
  localparam int autoneg_enable_bit  = 12;
  localparam int serdes_power_down   = 11;
  localparam int mac_isolate_bit     = 10;
  localparam int autoneg_restart_bit = 9;
  localparam int forced_duplex_bit   = 8;
  localparam int collision_test_bit  = 7;
  localparam int speed_code_high     = 6;
  // count the reset counter reaches; the soft reset bit self clears one cycle later, so the fiber logic reset is held 9 cycles
  localparam logic [3:0] fiber_reset_cycles = 4'h8;
  localparam logic [3:0] sel_clock_out   = 4'h0;
  localparam logic [3:0] sel_interrupt   = 4'h2;
  localparam logic [3:0] sel_link_status = 4'h3;
  localparam logic [3:0] sel_transmit_delimiter_pulse      = 4'h5;
  localparam logic [3:0] sel_receive_delimiter_pulse      = 4'h6;
  localparam logic [3:0] sel_wake        = 4'h7;
  localparam logic [3:0] sel_energy      = 4'h8;
  localparam logic [3:0] sel_prbs_err    = 4'h9;
  localparam logic [3:0] sel_led2        = 4'ha;
  localparam logic [3:0] sel_led3        = 4'hb;
  localparam logic [3:0] sel_crs         = 4'hc;
  localparam logic [3:0] sel_col         = 4'hd;
  localparam logic [3:0] sel_low         = 4'he;
  localparam logic [3:0] sel_high        = 4'hf;
  localparam logic [1:0] speed_10        = 2'h0;
  localparam logic [1:0] speed_100       = 2'h1;
  localparam logic [1:0] speed_1000      = 2'h2;
  // copper rate codes seen on copper_speed
  localparam logic [1:0] copper_100      = 2'h1;
  localparam logic [1:0] copper_1000     = 2'h2;
endpackage

// >>> rtl/pin_source_mux.sv
// module: one multipurpose output pin source selector
`timescale 1ns/1ps
module pin_source_mux (
  input  wire logic [3:0]  sel,
  input  wire logic [15:0] sources,
  output logic             pin_value
);
  // reserved codes index sources tied low by the caller
  always_comb begin
    pin_value = sources[sel];
  end
endmodule

// >>> rtl/pin_mux_and_fiber_ctrl_regs.sv
// module: pin function select and fiber/sgmii control register bank
//
// Overview of operation
// - pin 0 select in bits 3-0, reset selects second LED
// - energy detect select only meaningful at copper 1000 or 100 rate
// - pin 1 select in bits 7-4, same codes, reset selects wake on lan
// - sfd indication enabled forces pin 1 to transmit delimiter pulse
// - sfd indication enabled forces pin 0 to receive delimiter pulse
// - one fiber control register serves fiber, both bridges and media converter
// - bit 15 resets fiber logic, self clears when reset done
// - bit 14 enables mac side loopback
// - bits 6 and 13 form speed code, straps also load them
// - bit 12 enables autonegotiation, resets set, strap may override
// - bit 11 powers down serdes and holds its logic in reset
// - bit 10 isolates mac, ignored in sgmii to rgmii bridge mode
// - bit 9 restarts autonegotiation, self clears
// - bit 8 forces duplex in mii 100fx mode, resets full
// - bit 7 asserts collision whenever mac transmit enable is high
// - speed code bits 6 and 13 force sgmii speed only with autonegotiation off
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module pin_mux_and_fiber_ctrl_regs (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        strap_load,
  input  wire logic [1:0]  strap_speed,
  input  wire logic        strap_autoneg,
  input  wire logic        sfd_enable,
  input  wire logic        transmit_delimiter_pulse,
  input  wire logic        receive_delimiter_pulse,
  input  wire logic        clock_out_src,
  input  wire logic        interrupt_src,
  input  wire logic        link_status_src,
  input  wire logic        wake_on_lan_choice,
  input  wire logic        energy_detect_src,
  input  wire logic [1:0]  copper_speed,
  input  wire logic        prbs_error_src,
  input  wire logic        second_led_choice,
  input  wire logic        third_led_pin_choice,
  input  wire logic        crs_src,
  input  wire logic        col_src,
  input  wire logic        mii_100fx_mode,
  input  wire logic        sgmii_to_rgmii_bridge,
  input  wire logic        mac_tx_en,
  output logic             pin0_out,
  output logic             pin1_out,
  output logic             fiber_logic_reset,
  output logic             mac_loopback_en,
  output logic [1:0]       link_speed_code,
  output logic             autoneg_en,
  output logic             serdes_pd,
  output logic             serdes_logic_reset,
  output logic             mac_isolate,
  output logic             autoneg_restart,
  output logic             full_duplex,
  output logic             collision_out,
  output logic [1:0]       forced_sgmii_speed,
  output logic             forced_speed_valid
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers for asynchronous inputs

  logic [15:0] async_meta;
  logic [15:0] async_sync;
  logic [15:0] async_in;

  assign async_in = {strap_load, strap_autoneg, strap_speed, sfd_enable,
                     transmit_delimiter_pulse, receive_delimiter_pulse,
                     wake_on_lan_choice, energy_detect_src, prbs_error_src,
                     crs_src, col_src, mac_tx_en, link_status_src,
                     second_led_choice, third_led_pin_choice};

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      async_meta <= 16'h0000;
      async_sync <= 16'h0000;
    end else begin
      async_meta <= async_in;
      async_sync <= async_meta;
    end
  end

  logic       s_strap_load;
  logic       s_strap_an;
  logic [1:0] s_strap_speed;
  logic       s_sfd_en;
  logic       s_transmit_delimiter_pulse;
  logic       s_receive_delimiter_pulse;
  logic       s_wol;
  logic       s_energy;
  logic       s_prbs;
  logic       s_crs;
  logic       s_col;
  logic       s_tx_en;
  logic       s_link;
  logic       s_led2;
  logic       s_led3;

  assign s_strap_load  = async_sync[15];
  assign s_strap_an    = async_sync[14];
  assign s_strap_speed = async_sync[13:12];
  assign s_sfd_en      = async_sync[11];
  assign s_transmit_delimiter_pulse      = async_sync[10];
  assign s_receive_delimiter_pulse      = async_sync[9];
  assign s_wol         = async_sync[8];
  assign s_energy      = async_sync[7];
  assign s_prbs        = async_sync[6];
  assign s_crs         = async_sync[5];
  assign s_col         = async_sync[4];
  assign s_tx_en       = async_sync[3];
  assign s_link        = async_sync[2];
  assign s_led2        = async_sync[1];
  assign s_led3        = async_sync[0];

  ////////////////////////////////////////////////////////////////////////////////
  // register decode

  logic wr_pin;
  logic wr_fiber;

  // address match kept in one function for both write strobes; the read case decodes the same offsets
  function automatic logic addr_match(input logic [11:0] addr,
                                      input logic [11:0] offset);
    return addr == offset;
  endfunction

  assign wr_pin   = reg_wr && addr_match(reg_addr, pin_mux_pkg::pin_function_select_off);
  assign wr_fiber = reg_wr && addr_match(reg_addr, pin_mux_pkg::fiber_sgmii_control_off);

  ////////////////////////////////////////////////////////////////////////////////
  // pin function select register

  logic [15:0] pin_function_select_reg;

  // upper reserved fields are plain storage; software keeps them intact
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_function_select_reg <= pin_mux_pkg::pin_function_select_rst;
    end else if (wr_pin) begin
      pin_function_select_reg <= reg_wdata;
    end
  end

  logic [3:0] pin0_function_select;
  logic [3:0] pin1_function_select;

  assign pin0_function_select = pin_function_select_reg[pin_mux_pkg::pin0_sel_lsb +: 4];
  assign pin1_function_select = pin_function_select_reg[pin_mux_pkg::pin1_sel_lsb +: 4];

  ////////////////////////////////////////////////////////////////////////////////
  // fiber control register

  logic [15:0] fiber_sgmii_control_reg;
  logic [3:0]  reset_cnt_reg;
  logic        restart_seen_reg;

  // self clearing bits: hardware clear only when no new write sets them this cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fiber_sgmii_control_reg <= pin_mux_pkg::fiber_sgmii_control_rst;
    end else if (wr_fiber) begin
      fiber_sgmii_control_reg <= reg_wdata;
    end else begin
      // straps load as a level, so they must not stall the self clearing bits
      if (s_strap_load) begin
        fiber_sgmii_control_reg[pin_mux_pkg::speed_code_high] <= s_strap_speed[1];
        fiber_sgmii_control_reg[pin_mux_pkg::speed_code_low]  <= s_strap_speed[0];
        fiber_sgmii_control_reg[pin_mux_pkg::autoneg_enable_bit] <= s_strap_an;
      end
      if (fiber_sgmii_control_reg[pin_mux_pkg::fiber_soft_reset] &&
          reset_cnt_reg == pin_mux_pkg::fiber_reset_cycles) begin
        fiber_sgmii_control_reg[pin_mux_pkg::fiber_soft_reset] <= 1'b0;
      end
      if (restart_seen_reg) begin
        fiber_sgmii_control_reg[pin_mux_pkg::autoneg_restart_bit] <= 1'b0;
      end
    end
  end

  // counts how long the fiber logic has been held in soft reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_cnt_reg <= 4'h0;
    end else if (!fiber_sgmii_control_reg[pin_mux_pkg::fiber_soft_reset]) begin
      reset_cnt_reg <= 4'h0;
    end else if (reset_cnt_reg != pin_mux_pkg::fiber_reset_cycles) begin
      reset_cnt_reg <= 4'(reset_cnt_reg + 4'h1);
    end
  end

  // restart bit stands two cycles so the pulse reaches the autoneg engine
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      restart_seen_reg <= 1'b0;
    end else begin
      restart_seen_reg <= fiber_sgmii_control_reg[pin_mux_pkg::autoneg_restart_bit] &&
                          !wr_fiber;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control outputs

  logic [1:0] speed_code;

  assign speed_code = {fiber_sgmii_control_reg[pin_mux_pkg::speed_code_high],
                       fiber_sgmii_control_reg[pin_mux_pkg::speed_code_low]};

  // soft reset and loopback follow their bits one cycle late
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fiber_logic_reset <= 1'b0;
      mac_loopback_en   <= 1'b0;
    end else begin
      fiber_logic_reset <= fiber_sgmii_control_reg[pin_mux_pkg::fiber_soft_reset];
      mac_loopback_en   <= fiber_sgmii_control_reg[pin_mux_pkg::mac_side_loopback];
    end
  end

  // speed and autonegotiation controls
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_speed_code    <= pin_mux_pkg::speed_1000;
      autoneg_en         <= 1'b1;
      forced_sgmii_speed <= pin_mux_pkg::speed_1000;
      forced_speed_valid <= 1'b0;
      autoneg_restart    <= 1'b0;
    end else begin
      link_speed_code    <= speed_code;
      autoneg_en         <= fiber_sgmii_control_reg[pin_mux_pkg::autoneg_enable_bit];
      forced_sgmii_speed <= speed_code;
      // the forced speed means nothing while autonegotiation runs
      forced_speed_valid <= !fiber_sgmii_control_reg[pin_mux_pkg::autoneg_enable_bit];
      autoneg_restart    <= fiber_sgmii_control_reg[pin_mux_pkg::autoneg_restart_bit];
    end
  end

  // power down keeps the serdes logic in reset for as long as it stands
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      serdes_pd          <= 1'b0;
      serdes_logic_reset <= 1'b0;
    end else begin
      serdes_pd          <= fiber_sgmii_control_reg[pin_mux_pkg::serdes_power_down];
      serdes_logic_reset <= fiber_sgmii_control_reg[pin_mux_pkg::serdes_power_down];
    end
  end

  // isolate has no meaning when the mac side is the sgmii link
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mac_isolate <= 1'b0;
    end else begin
      mac_isolate <= fiber_sgmii_control_reg[pin_mux_pkg::mac_isolate_bit] &&
                     !sgmii_to_rgmii_bridge;
    end
  end

  // duplex and collision test
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      full_duplex   <= 1'b1;
      collision_out <= 1'b0;
    end else begin
      // half duplex only takes effect in the mii 100fx path
      full_duplex   <= fiber_sgmii_control_reg[pin_mux_pkg::forced_duplex_bit] ||
                       !mii_100fx_mode;
      collision_out <= (fiber_sgmii_control_reg[pin_mux_pkg::collision_test_bit] &&
                        s_tx_en) || s_col;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // multipurpose pin muxing

  logic [15:0] pin_sources;
  logic        energy_valid;
  logic        pin0_sel_value;
  logic        pin1_sel_value;

  assign energy_valid = (copper_speed == pin_mux_pkg::copper_1000) ||
                        (copper_speed == pin_mux_pkg::copper_100);

  always_comb begin
    pin_sources = 16'h0000;
    pin_sources[pin_mux_pkg::sel_clock_out]   = clock_out_src;
    pin_sources[pin_mux_pkg::sel_interrupt]   = interrupt_src;
    pin_sources[pin_mux_pkg::sel_link_status] = s_link;
    pin_sources[pin_mux_pkg::sel_transmit_delimiter_pulse]      = s_transmit_delimiter_pulse;
    pin_sources[pin_mux_pkg::sel_receive_delimiter_pulse]      = s_receive_delimiter_pulse;
    pin_sources[pin_mux_pkg::sel_wake]        = s_wol;
    pin_sources[pin_mux_pkg::sel_energy]      = s_energy && energy_valid;
    pin_sources[pin_mux_pkg::sel_prbs_err]    = s_prbs;
    pin_sources[pin_mux_pkg::sel_led2]        = s_led2;
    pin_sources[pin_mux_pkg::sel_led3]        = s_led3;
    pin_sources[pin_mux_pkg::sel_crs]         = s_crs;
    pin_sources[pin_mux_pkg::sel_col]         = s_col;
    pin_sources[pin_mux_pkg::sel_low]         = 1'b0;
    pin_sources[pin_mux_pkg::sel_high]        = 1'b1;
  end

  pin_source_mux u_pin0_mux (
    .sel       (pin0_function_select),
    .sources   (pin_sources),
    .pin_value (pin0_sel_value)
  );

  pin_source_mux u_pin1_mux (
    .sel       (pin1_function_select),
    .sources   (pin_sources),
    .pin_value (pin1_sel_value)
  );

  // sfd override wins over any programmed selection
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin0_out <= 1'b0;
      pin1_out <= 1'b0;
    end else begin
      pin0_out <= s_sfd_en ? s_receive_delimiter_pulse : pin0_sel_value;
      pin1_out <= s_sfd_en ? s_transmit_delimiter_pulse : pin1_sel_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        pin_mux_pkg::pin_function_select_off: reg_rdata <= pin_function_select_reg;
        pin_mux_pkg::fiber_sgmii_control_off: reg_rdata <= fiber_sgmii_control_reg;
        default:                              reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// >>> verification/pin_mux_props.sv
// checker: port timing relations of the pin mux and fiber control bank
`timescale 1ns/1ps
module pin_mux_props (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        sfd_enable,
  input wire logic        transmit_delimiter_pulse,
  input wire logic        receive_delimiter_pulse,
  input wire logic        mii_100fx_mode,
  input wire logic        sgmii_to_rgmii_bridge,
  input wire logic        pin0_out,
  input wire logic        pin1_out,
  input wire logic        fiber_logic_reset,
  input wire logic        mac_loopback_en,
  input wire logic [1:0]  link_speed_code,
  input wire logic        autoneg_en,
  input wire logic        serdes_pd,
  input wire logic        serdes_logic_reset,
  input wire logic        mac_isolate,
  input wire logic        autoneg_restart,
  input wire logic        full_duplex,
  input wire logic [1:0]  forced_sgmii_speed,
  input wire logic        forced_speed_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence sfd_held;
    sfd_enable && $past(sfd_enable) && $past(sfd_enable, 2) && $past(sfd_enable, 3);
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  a_loopback_follows: assert property ((reg_wr && reg_addr == 12'h0c00)
    |-> ##2 mac_loopback_en == $past(reg_wdata[14], 2))
    else $error("loopback output does not follow write");
  a_ctrl_follows: assert property ((reg_wr && reg_addr == 12'h0c00)
    |-> ##2 serdes_pd == $past(reg_wdata[11], 2)
    && forced_speed_valid == !$past(reg_wdata[12], 2)
    && link_speed_code == {$past(reg_wdata[6], 2), $past(reg_wdata[13], 2)})
    else $error("control outputs do not follow write");
  a_isolate_gated: assert property (mac_isolate |-> !$past(sgmii_to_rgmii_bridge))
    else $error("isolate active in bridge mode");
  a_pd_holds_reset: assert property (serdes_pd == serdes_logic_reset)
    else $error("power down without logic reset");
  a_speed_forced: assert property (forced_sgmii_speed == link_speed_code
    && forced_speed_valid == !autoneg_en)
    else $error("forced speed disagrees with control");
  a_restart_clears: assert property ($rose(autoneg_restart)
    |=> autoneg_restart ##1 !autoneg_restart)
    else $error("restart bit does not self clear");
  a_reset_clears: assert property ($rose(fiber_logic_reset)
    |-> fiber_logic_reset [*8] ##[1:2] !fiber_logic_reset)
    else $error("fiber reset length wrong");
  a_duplex_full: assert property (!$past(mii_100fx_mode) |-> full_duplex)
    else $error("half duplex outside mii fiber mode");
  a_sfd_pins: assert property (sfd_held
    |-> pin0_out == $past(receive_delimiter_pulse, 3)
    && pin1_out == $past(transmit_delimiter_pulse, 3))
    else $error("sfd pins not forced");
  c_sfd: cover property (sfd_held ##0 pin1_out);
  c_reset: cover property ($fell(fiber_logic_reset));
  c_restart: cover property ($rose(autoneg_restart));
endmodule
bind pin_mux_and_fiber_ctrl_regs pin_mux_props i_props (.*);

// >>> verification/pin_mux_and_fiber_ctrl_regs_tb.sv
// testbench: register, pin mux and fiber control scenarios
`timescale 1ns/1ps
module pin_mux_and_fiber_ctrl_regs_tb;
  typedef struct packed {logic [3:0] c; logic [11:0] s; logic e1; logic e0;} row_t;
  logic        sys_clk, arst_n, reg_wr, reg_rd, strap_load, strap_autoneg, sfd_enable;
  logic        mii_mode, bridge, mac_tx_en;
  logic [11:0] reg_addr, src;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [1:0]  strap_speed, copper_speed, lsc, fss;
  logic        p0, p1, flr, lbe, ane, spd, slr, iso, anr, fd, col, fsv;
  int          mismatches, checked;
  // one source per source code, all for reserved and low codes, none for high; each row also run with the sources inverted
  row_t rows [16] = '{'{4'h0, 12'h800, 1, 0}, '{4'h1, 12'hfff, 0, 0}, '{4'h2, 12'h400, 1, 0},
    '{4'h3, 12'h200, 1, 0}, '{4'h4, 12'hfff, 0, 0}, '{4'h5, 12'h100, 1, 0},
    '{4'h6, 12'h080, 1, 0}, '{4'h7, 12'h040, 1, 0}, '{4'h8, 12'h020, 1, 0},
    '{4'h9, 12'h010, 1, 0}, '{4'ha, 12'h008, 1, 0}, '{4'hb, 12'h004, 1, 0},
    '{4'hc, 12'h002, 1, 0}, '{4'hd, 12'h001, 1, 0}, '{4'he, 12'hfff, 0, 0},
    '{4'hf, 12'h000, 1, 1}};
  pin_mux_and_fiber_ctrl_regs i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .strap_load(strap_load), .strap_speed(strap_speed), .strap_autoneg(strap_autoneg),
    .sfd_enable(sfd_enable), .clock_out_src(src[11]), .interrupt_src(src[10]),
    .link_status_src(src[9]), .transmit_delimiter_pulse(src[8]),
    .receive_delimiter_pulse(src[7]), .wake_on_lan_choice(src[6]),
    .energy_detect_src(src[5]), .prbs_error_src(src[4]), .second_led_choice(src[3]),
    .third_led_pin_choice(src[2]), .crs_src(src[1]), .col_src(src[0]),
    .copper_speed(copper_speed), .mii_100fx_mode(mii_mode), .sgmii_to_rgmii_bridge(bridge),
    .mac_tx_en(mac_tx_en), .pin0_out(p0), .pin1_out(p1), .fiber_logic_reset(flr),
    .mac_loopback_en(lbe), .link_speed_code(lsc), .autoneg_en(ane), .serdes_pd(spd),
    .serdes_logic_reset(slr), .mac_isolate(iso), .autoneg_restart(anr), .full_duplex(fd),
    .collision_out(col), .forced_sgmii_speed(fss), .forced_speed_valid(fsv));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic settle();
    repeat (5) @(posedge sys_clk);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200us;
    mismatches++;
    test_done();
  end
  initial begin
    {arst_n, reg_wr, reg_rd, strap_load, strap_autoneg, sfd_enable} = '0;
    {mii_mode, bridge, mac_tx_en, reg_addr, src, reg_wdata, strap_speed} = '0;
    mismatches = 0;
    checked = 0;
    copper_speed = 2'h2;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(12'h01e0);
    check(d, 16'h417a);
    rd(12'h0c00);
    check(d, 16'h1140);
    check({lsc, ane, fd}, 16'h000b);
    foreach (rows[i]) begin
      wr(12'h01e0, {8'h41, rows[i].c, rows[i].c});
      src <= rows[i].s;
      settle();
      check({p1, p0}, {2{rows[i].e1}});
      src <= ~rows[i].s;
      settle();
      check({p1, p0}, {2{rows[i].e0}});
    end
    wr(12'h01e0, 16'h4188);
    src <= 12'h020;
    copper_speed <= 2'h0;
    settle();
    check({p1, p0}, 16'h0000);
    copper_speed <= 2'h1;
    settle();
    check({p1, p0}, 16'h0003);
    wr(12'h01e0, 16'h4177);
    src <= 12'h0c0;
    sfd_enable <= 1'b1;
    settle();
    check({p1, p0}, 16'h0001);
    src <= 12'h100;
    settle();
    check({p1, p0}, 16'h0002);
    sfd_enable <= 1'b0;
    wr(12'h0123, 16'hffff);
    rd(12'h0123);
    check(d, 16'h0000);
    rd(12'h01e0);
    check(d, 16'h4177);
    mac_tx_en <= 1'b1;
    src <= 12'h000;
    wr(12'h0c00, 16'h4d80);
    settle();
    check({lbe, slr, spd, iso, fd, lsc, fss, ane, fsv, col}, 16'h0f83);
    mac_tx_en <= 1'b0;
    settle();
    check({15'h0000, col}, 16'h0000);
    bridge <= 1'b1;
    mii_mode <= 1'b1;
    wr(12'h0c00, 16'h0440);
    settle();
    check({lbe, slr, spd, iso, fd, lsc, fss, ane, fsv, col}, 16'h0052);
    wr(12'h0c00, 16'h9140);
    for (int n = 0; n < 20 && (n == 0 || d[15] !== 1'b0); n++) rd(12'h0c00);
    check(d, 16'h1140);
    wr(12'h0c00, 16'h1340);
    @(posedge sys_clk);
    #1 check({15'h0000, anr}, 16'h0001);
    settle();
    rd(12'h0c00);
    check(d, 16'h1140);
    strap_speed <= 2'h1;
    strap_load <= 1'b1;
    settle();
    strap_load <= 1'b0;
    rd(12'h0c00);
    check(d, 16'h2100);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(12'h01e0);
    check(d, 16'h417a);
    rd(12'h0c00);
    check(d, 16'h1140);
    test_done();
  end
endmodule
